// ==== fps_consts.svh ====
// Constants of the flash program and erase sequencer.
`ifndef FPS_CONSTS_SVH
`define FPS_CONSTS_SVH
// Operation
// - Program pulse lasts 30 to 40 us.
// - Pulse is 57 or 8*speed+8 bus cycles.
// - Only 1.5 to 8.0 MHz is supported.
// - One byte per pass, or a whole row.
// - A row is 32 bytes.
// - Watchdog enabled: every byte one at a time.
// - Watchdog off, one row: row method.
// - Watchdog off, spanning rows: bytes, then last row.
// - High voltage under 125 us per byte.
// - Row high voltage total stays under 4 ms.
// - Interrupts blocked, entry mask restored at end.
// - Watchdog first serviced 61 bus cycles after start.
// - Protected erase fails unless test voltage present.
// - Mass erase regains access after failed security.
// - Returns address after last programmed byte.
// - Protect register address erases all, else page.
// - Erase lasts 4 to 5.5 ms from speed.
`define FPS_REG_CTRL    4'h0
`define FPS_REG_SPEED   4'h1
`define FPS_REG_COUNT   4'h2
`define FPS_REG_ADDR_LO 4'h3
`define FPS_REG_ADDR_HI 4'h4
`define FPS_REG_DATA    4'h5
`define FPS_REG_BPR     4'h6
`define FPS_REG_STATUS  4'h7
`define FPS_REG_NEXT_LO 4'h8
`define FPS_REG_NEXT_HI 4'h9
`define FPS_CTRL_ERASE  0
`define FPS_CTRL_PROG   1
`define FPS_CTRL_WDDIS  2
`define FPS_CORE_MHZ    50
`define FPS_TICK_MOD    (`FPS_CORE_MHZ * 4)
`define FPS_PROG_SLOW   16'h0039
`define FPS_PROG_FAST   8'h07
`define FPS_PROG_ADD    16'h0008
`define FPS_ERASE_US    4400
`define FPS_HV_MAX_US   125
`define FPS_ROW_MAX_US  4000
`define FPS_WD_FIRST    61
`define FPS_WD_PERIOD   1024
`define FPS_HV_SETUP    16'h000a
`define FPS_HV_HOLD     16'h000a
`define FPS_ROW_GAP     16'h0004
`define FPS_PAGE_MASK   16'hffc0
`define FPS_ROW_SHIFT   5
`define FPS_FLASH_START 16'hc000
`define FPS_BPR_ADDR    16'hff7e
`define FPS_BPR_NONE    8'hff
`define FPS_SPEED_RST   8'h08
`endif

// ==== fps_pkg.sv ====
// Types shared by the flash sequencer modules.
package fps_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ERASE = 3'h1,
    ST_ARM   = 3'h2,
    ST_SETUP = 3'h3,
    ST_PULSE = 3'h4,
    ST_GAP   = 3'h5,
    ST_HOLD  = 3'h6
  } fps_state_t;
  typedef struct packed {
    logic        hv;
    logic        erase;
    logic        mass;
    logic        pgm;
    logic [15:0] addr;
    logic [7:0]  data;
  } fps_flash_t;
endpackage

// ==== fps_timer.sv ====
// Down counter of bus cycles used for every timed phase.
`timescale 1ns/1ps
module fps_timer (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        load_i,
  input  wire logic        tick_i,
  input  wire logic [15:0] value_i,
  output logic             expired_o
);
  logic [15:0] count;
  logic [15:0] next_count;

  always_comb begin
    next_count = count;
    if (load_i) begin
      next_count = value_i;
    end else if (tick_i && count != 16'h0000) begin
      next_count = count - 16'h0001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      count <= 16'h0000;
    end else begin
      count <= next_count;
    end
  end

  assign expired_o = (count == 16'h0000);
endmodule

// ==== fps_sequencer.sv ====
// Flash program and erase sequencer with its register port.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "fps_consts.svh"
module fps_sequencer #(
  parameter logic [15:0] ERASE_PER_SPEED = 16'(`FPS_ERASE_US / 4),
  parameter logic [17:0] HV_MAX_CYC      = 18'(`FPS_HV_MAX_US * `FPS_CORE_MHZ),
  parameter logic [17:0] ROW_MAX_CYC     = 18'(`FPS_ROW_MAX_US * `FPS_CORE_MHZ)
) (
  input  wire logic           core_clk_i,
  input  wire logic           nrst_i,
  input  wire logic [3:0]     addr_i,
  input  wire logic [7:0]     wdata_i,
  input  wire logic           wr_i,
  input  wire logic           rd_i,
  input  wire logic           int_mask_i,
  input  wire logic           high_test_voltage_i,
  output logic [7:0]          rdata_o,
  output fps_pkg::fps_flash_t flash_o,
  output logic                wdog_kick_o,
  output logic                int_mask_o,
  output logic                busy_o,
  output logic                done_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  speed;
  logic [7:0]  count;
  logic [15:0] base_addr;
  logic [7:0]  bpr;
  logic        wd_dis;
  logic [7:0]  wptr;
  logic        hv_s1;
  logic        hv_s2;
  logic [7:0]  mem [0:255];
  logic [7:0]  next_speed;
  logic [7:0]  next_count;
  logic [15:0] next_base_addr;
  logic [7:0]  next_bpr;
  logic        next_wd_dis;
  logic [7:0]  next_wptr;
  logic [7:0]  next_rdata;
  logic        mem_we;
  logic        go_erase;
  logic        go_prog;

  fps_pkg::fps_state_t state;
  fps_pkg::fps_state_t next_state;
  fps_pkg::fps_flash_t next_flash;
  logic [15:0] cur;
  logic [7:0]  idx;
  logic [8:0]  left;
  logic [15:0] last_row;
  logic        row_mode;
  logic        err;
  logic        done_flag;
  logic        unsecured;
  logic        op_prog;
  logic        saved_mask;
  logic [15:0] next_addr;
  logic [7:0]  acc;
  logic [9:0]  wd_cnt;
  logic        wd_first;
  logic [15:0] next_cur;
  logic [7:0]  next_idx;
  logic [8:0]  next_left;
  logic [15:0] next_last_row;
  logic        next_row_mode;
  logic        next_err;
  logic        next_done_flag;
  logic        next_unsecured;
  logic        next_op_prog;
  logic        next_saved_mask;
  logic [15:0] next_next_addr;
  logic [7:0]  next_acc;
  logic [9:0]  next_wd_cnt;
  logic        next_wd_first;
  logic        next_kick;
  logic        next_int_mask;
  logic        next_busy;
  logic        next_done;
  logic        begin_op;
  logic        finish;
  logic        tmr_load;
  logic [15:0] tmr_val;
  logic        tmr_expired;
  logic        tick;
  logic [8:0]  acc_sum;

  logic [15:0] prog_cyc;
  logic [15:0] erase_cyc;
  logic        is_mass;
  logic        prot_hit;
  logic        erase_refused;
  logic        wd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Register port. Configuration writes are ignored while busy so that the
  // parameters of a running operation cannot shift underneath it.
  always_comb begin
    next_speed     = speed;
    next_count     = count;
    next_base_addr = base_addr;
    next_bpr       = bpr;
    next_wd_dis    = wd_dis;
    next_wptr      = wptr;
    next_rdata     = 8'h00;
    mem_we         = 1'b0;
    go_erase       = 1'b0;
    go_prog        = 1'b0;
    if (wr_i && !busy_o) begin
      unique case (addr_i)
        `FPS_REG_CTRL: begin
          next_wd_dis = wdata_i[`FPS_CTRL_WDDIS];
          go_erase    = wdata_i[`FPS_CTRL_ERASE];
          go_prog     = wdata_i[`FPS_CTRL_PROG] & ~wdata_i[`FPS_CTRL_ERASE];
        end
        `FPS_REG_SPEED: next_speed = wdata_i;
        `FPS_REG_COUNT: begin
          next_count = wdata_i;
          next_wptr  = 8'h00;
        end
        `FPS_REG_ADDR_LO: next_base_addr[7:0] = wdata_i;
        `FPS_REG_ADDR_HI: next_base_addr[15:8] = wdata_i;
        `FPS_REG_DATA: begin
          mem_we    = 1'b1;
          next_wptr = 8'(wptr + 8'h01);
        end
        `FPS_REG_BPR: next_bpr = wdata_i;
        default: ;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        `FPS_REG_CTRL:    next_rdata = {5'h00, wd_dis, 2'h0};
        `FPS_REG_SPEED:   next_rdata = speed;
        `FPS_REG_COUNT:   next_rdata = count;
        `FPS_REG_ADDR_LO: next_rdata = base_addr[7:0];
        `FPS_REG_ADDR_HI: next_rdata = base_addr[15:8];
        `FPS_REG_DATA:    next_rdata = wptr;
        `FPS_REG_BPR:     next_rdata = bpr;
        `FPS_REG_STATUS:  next_rdata = {4'h0, unsecured, err, done_flag, busy_o};
        `FPS_REG_NEXT_LO: next_rdata = next_addr[7:0];
        `FPS_REG_NEXT_HI: next_rdata = next_addr[15:8];
        default:          next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      speed     <= `FPS_SPEED_RST;
      count     <= 8'h00;
      base_addr <= 16'h0000;
      bpr       <= `FPS_BPR_NONE;
      wd_dis    <= 1'b0;
      wptr      <= 8'h00;
      rdata_o   <= 8'h00;
      hv_s1     <= 1'b0;
      hv_s2     <= 1'b0;
    end else begin
      speed     <= next_speed;
      count     <= next_count;
      base_addr <= next_base_addr;
      bpr       <= next_bpr;
      wd_dis    <= next_wd_dis;
      wptr      <= next_wptr;
      rdata_o   <= next_rdata;
      hv_s1     <= high_test_voltage_i;
      hv_s2     <= hv_s1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (mem_we) begin
      mem[wptr] <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timing and erase qualification.
  assign prog_cyc = (speed < `FPS_PROG_FAST) ? `FPS_PROG_SLOW
                  : 16'({5'h00, speed, 3'h0} + `FPS_PROG_ADD);
  assign erase_cyc = 16'(ERASE_PER_SPEED * {8'h00, speed});
  assign is_mass = (base_addr == `FPS_BPR_ADDR);
  assign prot_hit = (bpr != `FPS_BPR_NONE) && (is_mass || base_addr >= {bpr, 8'h00});
  // The test voltage bypasses protection, which also opens the mass erase path.
  assign erase_refused = (base_addr < `FPS_FLASH_START) || (prot_hit && !hv_s2);
  assign wd_hit = (wd_cnt == (wd_first ? 10'(`FPS_WD_FIRST - 1) : 10'(`FPS_WD_PERIOD - 1)));
  // A fractional divider turns the core clock into bus-cycle ticks at the
  // operating frequency given by the speed parameter; out-of-range speeds
  // give timing that the flash does not tolerate.
  assign acc_sum = {1'b0, acc} + {1'b0, speed};
  assign tick = (acc_sum >= 9'(`FPS_TICK_MOD));

  fps_timer u_timer (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .load_i     (tmr_load),
    .tick_i     (tick),
    .value_i    (tmr_val),
    .expired_o  (tmr_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer. Blank check and verify are left to software.
  always_comb begin
    next_state      = state;
    next_flash      = flash_o;
    next_cur        = cur;
    next_idx        = idx;
    next_left       = left;
    next_last_row   = last_row;
    next_row_mode   = row_mode;
    next_err        = err;
    next_done_flag  = done_flag;
    next_unsecured  = unsecured;
    next_op_prog    = op_prog;
    next_saved_mask = saved_mask;
    next_next_addr  = next_addr;
    next_wd_cnt     = wd_cnt;
    next_wd_first   = wd_first;
    next_kick       = 1'b0;
    next_int_mask   = int_mask_o;
    next_busy       = busy_o;
    next_done       = 1'b0;
    begin_op        = 1'b0;
    finish          = 1'b0;
    tmr_load        = 1'b0;
    tmr_val         = 16'h0000;
    next_acc        = tick ? 8'(acc_sum - 9'(`FPS_TICK_MOD)) : acc_sum[7:0];
    if (busy_o && !wd_dis && tick) begin
      next_wd_cnt = wd_hit ? 10'h000 : 10'(wd_cnt + 10'h001);
      next_kick   = wd_hit;
      if (wd_hit) begin
        next_wd_first = 1'b0;
      end
    end
    unique case (state)
      fps_pkg::ST_IDLE: begin
        if (go_erase) begin
          next_err       = erase_refused;
          next_done_flag = erase_refused;
          next_done      = erase_refused;
          next_op_prog   = 1'b0;
          if (!erase_refused) begin
            begin_op         = 1'b1;
            next_state       = fps_pkg::ST_ERASE;
            next_flash.hv    = 1'b1;
            next_flash.erase = 1'b1;
            next_flash.mass  = is_mass;
            next_flash.addr  = is_mass ? base_addr : (base_addr & `FPS_PAGE_MASK);
            tmr_load         = 1'b1;
            tmr_val          = erase_cyc;
          end
        end else if (go_prog) begin
          next_err       = 1'b0;
          next_op_prog   = 1'b1;
          next_done_flag = (count == 8'h00);
          next_done      = (count == 8'h00);
          next_next_addr = base_addr;
          if (count != 8'h00) begin
            begin_op      = 1'b1;
            next_state    = fps_pkg::ST_ARM;
            next_cur      = base_addr;
            next_idx      = 8'h00;
            next_left     = {1'b0, count};
            next_last_row = 16'(base_addr + {8'h00, count} - 16'h0001);
          end
        end
      end
      fps_pkg::ST_ERASE: begin
        if (tmr_expired) begin
          next_flash.hv    = 1'b0;
          next_flash.erase = 1'b0;
          next_flash.mass  = 1'b0;
          next_unsecured   = unsecured | flash_o.mass;
          finish           = 1'b1;
        end
      end
      fps_pkg::ST_ARM: begin
        // Row method only when the watchdog is off and the rest fits the last row.
        next_row_mode = wd_dis && (cur[15:`FPS_ROW_SHIFT] == last_row[15:`FPS_ROW_SHIFT]);
        next_flash.hv = 1'b1;
        next_state    = fps_pkg::ST_SETUP;
        tmr_load      = 1'b1;
        tmr_val       = `FPS_HV_SETUP;
      end
      fps_pkg::ST_SETUP, fps_pkg::ST_GAP: begin
        if (tmr_expired) begin
          next_state      = fps_pkg::ST_PULSE;
          next_flash.pgm  = 1'b1;
          next_flash.addr = cur;
          next_flash.data = mem[idx];
          tmr_load        = 1'b1;
          tmr_val         = prog_cyc;
        end
      end
      fps_pkg::ST_PULSE: begin
        if (tmr_expired) begin
          next_flash.pgm = 1'b0;
          next_cur       = 16'(cur + 16'h0001);
          next_idx       = 8'(idx + 8'h01);
          next_left      = 9'(left - 9'h001);
          tmr_load       = 1'b1;
          // Looping inside one voltage window writes every remaining byte of the last row.
          if (row_mode && left != 9'h001) begin
            next_state = fps_pkg::ST_GAP;
            tmr_val    = `FPS_ROW_GAP;
          end else begin
            next_state = fps_pkg::ST_HOLD;
            tmr_val    = `FPS_HV_HOLD;
          end
        end
      end
      fps_pkg::ST_HOLD: begin
        if (tmr_expired) begin
          // Dropping the voltage after each pass bounds it per byte and per row.
          next_flash.hv = 1'b0;
          if (left == 9'h000) begin
            next_next_addr = cur;
            finish         = 1'b1;
          end else begin
            next_state = fps_pkg::ST_ARM;
          end
        end
      end
      default: next_state = fps_pkg::ST_IDLE;
    endcase
    if (begin_op) begin
      next_busy       = 1'b1;
      next_saved_mask = int_mask_i;
      next_int_mask   = 1'b1;
      next_wd_cnt     = 10'h000;
      next_wd_first   = 1'b1;
      next_done_flag  = 1'b0;
    end
    if (finish) begin
      next_state     = fps_pkg::ST_IDLE;
      next_busy      = 1'b0;
      next_done      = 1'b1;
      next_done_flag = 1'b1;
      next_int_mask  = saved_mask;
    end
    if (!busy_o && !begin_op) begin
      next_int_mask = int_mask_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state       <= fps_pkg::ST_IDLE;
      flash_o     <= '0;
      cur         <= 16'h0000;
      idx         <= 8'h00;
      left        <= 9'h000;
      last_row    <= 16'h0000;
      row_mode    <= 1'b0;
      err         <= 1'b0;
      done_flag   <= 1'b0;
      unsecured   <= 1'b0;
      op_prog     <= 1'b0;
      saved_mask  <= 1'b0;
      next_addr   <= 16'h0000;
      acc         <= 8'h00;
      wd_cnt      <= 10'h000;
      wd_first    <= 1'b0;
      wdog_kick_o <= 1'b0;
      int_mask_o  <= 1'b0;
      busy_o      <= 1'b0;
      done_o      <= 1'b0;
    end else begin
      state       <= next_state;
      flash_o     <= next_flash;
      cur         <= next_cur;
      idx         <= next_idx;
      left        <= next_left;
      last_row    <= next_last_row;
      row_mode    <= next_row_mode;
      err         <= next_err;
      done_flag   <= next_done_flag;
      unsecured   <= next_unsecured;
      op_prog     <= next_op_prog;
      saved_mask  <= next_saved_mask;
      next_addr   <= next_next_addr;
      acc         <= next_acc;
      wd_cnt      <= next_wd_cnt;
      wd_first    <= next_wd_first;
      wdog_kick_o <= next_kick;
      int_mask_o  <= next_int_mask;
      busy_o      <= next_busy;
      done_o      <= next_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic [15:0] h_ticks;
  logic [17:0] h_hv;
  logic [7:0]  h_ops;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      h_ticks <= 16'h0000;
      h_hv    <= 18'h00000;
      h_ops   <= 8'h00;
    end else begin
      h_ticks <= (flash_o.pgm || flash_o.erase)
               ? 16'(h_ticks + {15'h0000, tick && !tmr_expired}) : 16'h0000;
      h_hv    <= (flash_o.hv && !flash_o.erase) ? 18'(h_hv + 18'h00001) : 18'h00000;
      h_ops   <= (busy_o && h_ops != 8'hff) ? 8'(h_ops + {7'h00, tick}) : 8'h00;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_finish;
    $fell(busy_o);
  endsequence
  sequence s_refuse;
    state == fps_pkg::ST_IDLE && go_erase && erase_refused;
  endsequence

  property p_pulse_len;
    $fell(flash_o.pgm) |-> h_ticks == prog_cyc;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("program pulse length wrong");
  property p_erase_len;
    $fell(flash_o.erase) |-> h_ticks == erase_cyc;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase length wrong");
  property p_hv_byte;
    flash_o.hv && !row_mode && !flash_o.erase |-> h_hv < HV_MAX_CYC;
  endproperty
  a_hv_byte: assert property (p_hv_byte) else $error("byte voltage too long");
  property p_hv_row;
    flash_o.hv && row_mode |-> h_hv < ROW_MAX_CYC;
  endproperty
  a_hv_row: assert property (p_hv_row) else $error("row voltage too long");
  property p_wd_first;
    wdog_kick_o && $past(wd_first) |-> h_ops == 8'(`FPS_WD_FIRST);
  endproperty
  a_wd_first: assert property (p_wd_first) else $error("first service mistimed");
  property p_mask;
    busy_o |-> int_mask_o;
  endproperty
  a_mask: assert property (p_mask) else $error("interrupts not blocked");
  property p_mask_restore;
    s_finish |-> int_mask_o == saved_mask;
  endproperty
  a_mask_restore: assert property (p_mask_restore) else $error("mask not restored");
  property p_done;
    s_finish |-> done_o ##1 !done_o;
  endproperty
  a_done: assert property (p_done) else $error("done pulse missing");
  property p_next_addr;
    op_prog ##0 s_finish |-> next_addr == 16'(base_addr + {8'h00, count});
  endproperty
  a_next_addr: assert property (p_next_addr) else $error("return address wrong");
  property p_row_wd;
    flash_o.pgm && row_mode |-> wd_dis
      && flash_o.addr[15:`FPS_ROW_SHIFT] == last_row[15:`FPS_ROW_SHIFT];
  endproperty
  a_row_wd: assert property (p_row_wd) else $error("row method misused");
  property p_refuse;
    s_refuse |=> done_o && err && !busy_o && !flash_o.erase;
  endproperty
  a_refuse: assert property (p_refuse) else $error("protected erase went ahead");
endmodule

// ==== fps_flash_model.sv ====
// Behavioural flash array with its high-voltage supply, watching the sequencer.
`timescale 1ns/1ps
module fps_flash_model (
  input  wire logic                core_clk_i,
  input  wire logic                nrst_i,
  input  wire fps_pkg::fps_flash_t flash_i
);
  logic [7:0]          mem [0:16383];
  fps_pkg::fps_flash_t prv;
  int                  hv_len, pls_len, last_pls, last_hv, sess, pulses, cur, last_cur;
  int                  erases, max1_hv;
  // A fresh array holds zeros so that an erase that never happens cannot pass.
  initial begin
    for (int i = 0; i < 16384; i++) mem[i] = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      prv = '0;
      hv_len = 0;
      pls_len = 0;
    end else begin
      if (flash_i.hv) hv_len++;
      if (flash_i.pgm) pls_len++;
      if (flash_i.pgm && !prv.pgm) begin
        mem[flash_i.addr[13:0]] &= flash_i.data;
        cur++;
        pulses++;
      end
      if (!flash_i.pgm && prv.pgm) begin
        last_pls = pls_len;
        pls_len = 0;
      end
      if (!flash_i.hv && prv.hv) begin
        last_hv = hv_len;
        hv_len = 0;
        sess++;
        last_cur = cur;
        cur = 0;
        if (last_cur == 1 && last_hv > max1_hv) max1_hv = last_hv;
        if (prv.erase) begin
          erases++;
          for (int i = 0; i < 16384; i++)
            if (prv.mass || i[13:6] == prv.addr[13:6]) mem[i] = 8'hff;
        end
      end
      prv = flash_i;
    end
  end
endmodule

// ==== fps_sequencer_tb.sv ====
// Self-checking bench of the flash sequencer against the flash array model.
`timescale 1ns/1ps
module fps_sequencer_tb;
  localparam int EPS = 4;
  logic                clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, imask = 1'b0, htv = 1'b0;
  logic [3:0]          addr = 4'h0;
  logic [7:0]          wdata = 8'h00, rdata, d;
  logic                kick, imask_o, busy, done;
  fps_pkg::fps_flash_t flash;
  logic [7:0]          dat [0:3];
  logic [15:0]         a;
  int                  mismatches = 0, comparisons = 0, cyc, kk, s0, p0, e0, spd, n;
  always #10 clk = ~clk;
  fps_sequencer #(.ERASE_PER_SPEED(16'(EPS))) i_fps_sequencer (.core_clk_i(clk), .nrst_i(nrst),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .int_mask_i(imask),
    .high_test_voltage_i(htv), .rdata_o(rdata), .flash_o(flash), .wdog_kick_o(kick),
    .int_mask_o(imask_o), .busy_o(busy), .done_o(done));
  fps_flash_model i_fps_flash_model (.core_clk_i(clk), .nrst_i(nrst), .flash_i(flash));
  //////////////////////////////////////////////////////////////////////////////
  function automatic int pulse_cyc(input int s);
    return ((s < 7) ? 57 : 8 * s + 8) * 200 / s;
  endfunction
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic end_sim;
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] i, input logic [7:0] v);
    @(posedge clk);
    addr <= i;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] i, output logic [7:0] v);
    @(posedge clk);
    addr <= i;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Each operation is watched cycle by cycle, so the first watchdog kick is timed here.
  task automatic run_op(input logic [7:0] ctrl);
    int ex;
    ex = 61 * 200 / spd;
    s0 = i_fps_flash_model.sess;
    p0 = i_fps_flash_model.pulses;
    e0 = i_fps_flash_model.erases;
    wr_reg(4'h0, ctrl);
    kk = -1;
    for (cyc = 0; cyc < 60000; cyc++) begin
      #1;
      if (kick === 1'b1 && kk < 0) kk = cyc;
      if (busy === 1'b1) chk(imask_o === 1'b1, "mask clear while busy");
      if (done === 1'b1) break;
      @(posedge clk);
    end
    if (cyc == 60000) begin
      chk(1'b0, "operation timeout");
      end_sim();
    end
    @(posedge clk);
    #1 chk(imask_o === imask && busy === 1'b0, "mask not restored");
    if (ctrl[2]) chk(kk < 0, "kick with watchdog off");
    else if (cyc > ex + 200 / spd + 3)
      chk(kk >= ex - 200 / spd - 3 && kk <= ex + 200 / spd + 3, "first kick time");
  endtask
  task automatic prog(input logic [15:0] a0, input int cnt, input logic wdd);
    logic [7:0]  lo, hi;
    logic [15:0] ak;
    int          ex;
    wr_reg(4'h1, 8'(spd));
    wr_reg(4'h2, 8'(cnt));
    wr_reg(4'h3, a0[7:0]);
    wr_reg(4'h4, a0[15:8]);
    for (int k = 0; k < cnt; k++) wr_reg(4'h5, dat[k]);
    run_op({5'h00, wdd, 2'b10});
    for (int k = 0; k < cnt; k++) begin
      ak = a0 + 16'(k);
      chk(i_fps_flash_model.mem[ak[13:0]] === dat[k], "byte not programmed");
    end
    rd_reg(4'h8, lo);
    rd_reg(4'h9, hi);
    chk({hi, lo} === a0 + 16'(cnt), "next address");
    ex = pulse_cyc(spd);
    if (cnt == 0) chk(cyc <= 1 && i_fps_flash_model.pulses == p0, "empty program");
    else begin
      chk(i_fps_flash_model.pulses - p0 == cnt, "pulse count");
      chk(i_fps_flash_model.last_pls >= ex - 200 / spd - 2 &&
          i_fps_flash_model.last_pls <= ex + 200 / spd + 2, "pulse length");
      chk(i_fps_flash_model.last_pls >= 1500 && i_fps_flash_model.last_pls <= 2000,
          "pulse outside 30 to 40 us");
      chk(i_fps_flash_model.max1_hv < 6250, "byte high voltage too long");
      if (!wdd) chk(i_fps_flash_model.sess - s0 == cnt, "not byte method");
    end
  endtask
  task automatic erase(input logic [15:0] a0, input logic ok);
    wr_reg(4'h1, 8'(spd));
    wr_reg(4'h3, a0[7:0]);
    wr_reg(4'h4, a0[15:8]);
    run_op(8'h01);
    chk(i_fps_flash_model.erases - e0 == (ok ? 1 : 0), "erase outcome");
    if (ok) chk(i_fps_flash_model.last_hv >= EPS * 200 - 400 / spd - 4 &&
                i_fps_flash_model.last_hv <= EPS * 200 + 400 / spd + 4, "erase time");
    else chk(cyc <= 1, "refused erase timing");
    rd_reg(4'h7, d);
    chk(d[2] === !ok, "error flag");
    chk(d[1:0] === 2'b10, "status after operation");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(2));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(4'h1, d);
    chk(d === 8'h08, "speed reset value");
    rd_reg(4'h6, d);
    chk(d === 8'hff, "protect reset value");
    rd_reg(4'h7, d);
    chk(d === 8'h00, "status reset value");
    rd_reg(4'ha, d);
    chk(d === 8'h00, "unmapped read");
    @(posedge clk) htv <= 1'b1;
    repeat (4) @(posedge clk);
    spd = 20;
    erase(16'hff7e, 1'b1);
    chk(i_fps_flash_model.mem[0] === 8'hff && i_fps_flash_model.mem[16383] === 8'hff,
        "mass erase");
    rd_reg(4'h7, d);
    chk(d[3] === 1'b1, "access not regained");
    repeat (4) begin
      spd = 6 + $urandom_range(26);
      @(posedge clk) imask <= 1'($urandom);
      a = 16'hc000 + 16'($urandom_range(16'h2fff));
      n = 1 + $urandom_range(2);
      for (int k = 0; k < 4; k++) dat[k] = 8'($urandom);
      prog(a, n, 1'b0);
    end
    // The slowest speed takes the fixed pulse length of the low-frequency band.
    spd = 6;
    @(posedge clk) imask <= 1'b0;
    dat = '{8'h55, 8'haa, 8'h5a, 8'ha5};
    prog(16'hf048, 3, 1'b1);
    chk(i_fps_flash_model.sess - s0 == 1, "not row method");
    spd = 32;
    prog(16'hf01e, 4, 1'b1);
    chk(i_fps_flash_model.sess - s0 == 3 && i_fps_flash_model.last_cur == 2,
        "row split");
    erase(16'hf021, 1'b1);
    chk(i_fps_flash_model.mem[14'h301e] === 8'hff && i_fps_flash_model.mem[14'h3021] === 8'hff
        && i_fps_flash_model.mem[14'h3048] === 8'h55, "page erase extent");
    prog(16'hf100, 0, 1'b0);
    wr_reg(4'h6, 8'hfe);
    htv <= 1'b0;
    repeat (4) @(posedge clk);
    erase(16'hff00, 1'b0);
    @(posedge clk) htv <= 1'b1;
    repeat (4) @(posedge clk);
    erase(16'hff00, 1'b1);
    end_sim();
  end
endmodule
